/* File: count_source.sv */
// Far-side model: count pulse sources and reset inputs of the counter.
// Assumes its tasks are called right after a rising clk edge.
`timescale 1ns/1ns
module count_source (
  // Clock
  input wire logic clk,
  // Count and reset lines
  output logic countInputA,
  output logic countInputB,
  output logic resetA,
  output logic resetB
);
  initial begin
    countInputA = 1'b0;
    countInputB = 1'b0;
    resetA = 1'b0;
    resetB = 1'b0;
  end

  // High one cycle, low one cycle: the fastest rate the inputs accept
  task automatic pulse(input logic onB, input int n);
    for (int i = 0; i < n; i++) begin
      if (onB) countInputB <= 1'b1;
      else countInputA <= 1'b1;
      @(posedge clk);
      countInputA <= 1'b0;
      countInputB <= 1'b0;
      @(posedge clk);
    end
  endtask : pulse

  task automatic hold(input logic a, input logic b);
    resetA <= a;
    resetB <= b;
    @(posedge clk);
  endtask : hold
endmodule : count_source

/* File: preset_counter.sv */
// Batch and dual preset counter with an APB register slave.
// Assumes synchronous inputs and a 10 MHz clock; one domain.
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ns
`include "preset_counter_consts.svh"
module preset_counter #(
  parameter int W = 24
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Count and reset inputs
  input wire logic countInputA,
  input wire logic countInputB,
  input wire logic resetA,
  input wire logic resetB,
  // Output lines
  output logic outputLineA,
  output logic outputLineB,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  logic riseA;
  logic riseB;
  logic [2:0] cfgBits_q;
  logic subMode_q;
  logic fourDigit_q;
  logic [W-1:0] preset_q;
  logic [W-1:0] batchSet_q;
  logic [W:0] dualSet_q;
  logic [W-1:0] pv_q;
  logic [W-1:0] aux_q;
  logic [W-1:0] pvA_q;
  logic [W-1:0] pvB_q;
  logic mainOut_q;
  logic batchOut_q;
  logic batchMem_q;
  logic overflow_q;
  logic [W-1:0] fullScale;
  logic [W:0] dualVal;
  logic [W:0] dualRaw;
  logic [W:0] negLimit;
  logic effA;
  logic effB;
  logic apbWr;
  logic keyPulse;
  logic restorePulse;
  logic complete;
  logic [W-1:0] batchNext;
  logic dualMatch;
  preset_counter_pkg::config_t cfg;
  pulse_edge edgeA (
    .clk(clk),
    .rst(rst),
    .level(countInputA),
    .rise(riseA)
  );
  pulse_edge edgeB (
    .clk(clk),
    .rst(rst),
    .level(countInputB),
    .rise(riseB)
  );
  function automatic logic [W-1:0] wrapInc(input logic [W-1:0] v,
                                           input logic [W-1:0] fs);
    wrapInc = (v >= fs) ? '0 : v + 1'b1;
  endfunction : wrapInc
  always_comb begin
    unique case (cfgBits_q)
      3'h1: cfg = preset_counter_pkg::CfgTwoStage;
      3'h2: cfg = preset_counter_pkg::CfgTotal;
      3'h3: cfg = preset_counter_pkg::CfgBatch;
      3'h4: cfg = preset_counter_pkg::CfgDual;
      default: cfg = preset_counter_pkg::CfgSingle;
    endcase
  end
  assign fullScale = fourDigit_q ? W'(`PC_MAX4) : W'(`PC_MAX6);
  assign negLimit = fourDigit_q ? (W+1)'(`PC_NEGMIN4) : (W+1)'(`PC_NEGMIN6);
  assign apbWr = psel & penable & pready & pwrite;
  assign keyPulse = apbWr && paddr == `PC_OFS_CMD
                    && pwdata[`PC_CMD_RESETKEY_BIT];
  assign restorePulse = apbWr && paddr == `PC_OFS_CMD
                        && pwdata[`PC_CMD_POWERRESTORE_BIT];
  // Count completion of the main preset counter
  assign complete = riseA && !resetA && !overflow_q
                    && (cfg != preset_counter_pkg::CfgDual)
                    && preset_q != '0 && pv_q + 1'b1 == preset_q;
  assign effA = (cfg == preset_counter_pkg::CfgDual) && resetA;
  assign effB = (cfg == preset_counter_pkg::CfgDual) && resetB;
  always_comb begin
    logic [W:0] a;
    logic [W:0] b;
    a = effA ? '0 : {1'b0, pvA_q};
    b = effB ? '0 : {1'b0, pvB_q};
    dualRaw = subMode_q ? a - b : a + b;
    dualVal = dualRaw;
    if (dualRaw[W] && subMode_q) begin
      if (-dualRaw > negLimit) begin
        dualVal = -negLimit;
      end
    end else if (dualRaw > {1'b0, fullScale}) begin
      dualVal = {1'b0, fullScale};
    end
  end
  assign dualMatch = dualVal == dualSet_q;
  assign batchNext = wrapInc(aux_q, fullScale);
  // Configuration registers
  always_ff @(posedge clk) begin
    if (rst) begin
      cfgBits_q <= 3'h0;
      subMode_q <= 1'b0;
      fourDigit_q <= 1'b0;
      preset_q <= '0;
      batchSet_q <= '0;
      dualSet_q <= '0;
    end else if (apbWr) begin
      unique case (paddr)
        `PC_OFS_CTRL: begin
          cfgBits_q <= pwdata[`PC_CTRL_CFG_LSB +: 3];
          subMode_q <= pwdata[`PC_CTRL_SUB_BIT];
          fourDigit_q <= pwdata[`PC_CTRL_FOUR_BIT];
        end
        `PC_OFS_PRESET: preset_q <= pwdata[W-1:0];
        `PC_OFS_BATCHSET: batchSet_q <= pwdata[W-1:0];
        `PC_OFS_DUALSET: dualSet_q <= pwdata[W:0];
        default: ;
      endcase
    end
  end
  // Main present value
  always_ff @(posedge clk) begin
    if (rst) begin
      pv_q <= '0;
    end else if (keyPulse || (resetA &&
                 cfg != preset_counter_pkg::CfgDual)) begin
      pv_q <= '0;
    end else if (complete) begin
      pv_q <= '0;
    end else if (riseA && !overflow_q &&
                 cfg != preset_counter_pkg::CfgDual) begin
      pv_q <= wrapInc(pv_q, fullScale);
    end
  end
  // Total or batch count
  always_ff @(posedge clk) begin
    if (rst) begin
      aux_q <= '0;
    end else if (keyPulse) begin
      aux_q <= '0;
    end else if (resetB && (cfg == preset_counter_pkg::CfgBatch ||
                 cfg == preset_counter_pkg::CfgTotal)) begin
      aux_q <= '0;
    end else if (cfg == preset_counter_pkg::CfgTotal && riseA &&
                 !resetA && !overflow_q) begin
      aux_q <= wrapInc(aux_q, fullScale);
    end else if (cfg == preset_counter_pkg::CfgBatch && complete) begin
      aux_q <= batchNext;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      pvA_q <= '0;
      pvB_q <= '0;
      overflow_q <= 1'b0;
    end else if (keyPulse) begin
      pvA_q <= '0;
      pvB_q <= '0;
      overflow_q <= 1'b0;
    end else if (cfg == preset_counter_pkg::CfgDual) begin
      if (resetA) begin
        pvA_q <= '0;
      end else if (riseA && !overflow_q) begin
        if (pvA_q >= fullScale) begin
          overflow_q <= 1'b1;
        end else begin
          pvA_q <= pvA_q + 1'b1;
        end
      end
      if (resetB) begin
        pvB_q <= '0;
      end else if (riseB && !overflow_q) begin
        if (pvB_q >= fullScale) begin
          overflow_q <= 1'b1;
        end else begin
          pvB_q <= pvB_q + 1'b1;
        end
      end
    end
  end
  // Main output, self-holding; in dual mode it follows the match each cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      mainOut_q <= 1'b0;
    end else if (keyPulse) begin
      mainOut_q <= 1'b0;
    end else if (cfg == preset_counter_pkg::CfgDual) begin
      mainOut_q <= dualMatch && !overflow_q;
    end else if (resetA) begin
      mainOut_q <= 1'b0;
    end else if (complete) begin
      mainOut_q <= 1'b1;
    end
  end
  // Batch output; memory has no reset so it outlives a power loss
  always_ff @(posedge clk) begin
    if (rst) begin
      batchOut_q <= 1'b0;
    end else if (keyPulse || (resetB &&
                 cfg == preset_counter_pkg::CfgBatch)) begin
      batchOut_q <= 1'b0;
      batchMem_q <= 1'b0;
    end else if (restorePulse && batchMem_q) begin
      batchOut_q <= 1'b1;
    end else if (cfg == preset_counter_pkg::CfgBatch &&
                 batchSet_q != '0 && aux_q >= batchSet_q) begin
      batchOut_q <= 1'b1;
      batchMem_q <= 1'b1;
    end
  end
  // Output lines
  always_ff @(posedge clk) begin
    if (rst) begin
      outputLineA <= 1'b0;
      outputLineB <= 1'b0;
    end else if (cfg == preset_counter_pkg::CfgBatch) begin
      outputLineA <= batchOut_q;
      outputLineB <= mainOut_q;
    end else begin
      outputLineA <= mainOut_q;
      outputLineB <= mainOut_q;
    end
  end
  // APB read data and zero-wait answer
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          `PC_OFS_CTRL: prdata <= 32'({fourDigit_q, subMode_q,
                                       cfgBits_q});
          `PC_OFS_PRESET: prdata <= 32'(preset_q);
          `PC_OFS_BATCHSET: prdata <= 32'(batchSet_q);
          `PC_OFS_DUALSET: prdata <= 32'($signed(dualSet_q));
          `PC_OFS_PV: prdata <= 32'(pv_q);
          `PC_OFS_AUX: prdata <= 32'(aux_q);
          `PC_OFS_PVA: prdata <= overflow_q ? 32'hffffffff : 32'(pvA_q);
          `PC_OFS_PVB: prdata <= overflow_q ? 32'hffffffff : 32'(pvB_q);
          `PC_OFS_DUAL: prdata <= 32'($signed(dualVal));
          `PC_OFS_STATUS: prdata <= 32'({overflow_q, batchOut_q,
                                         mainOut_q});
          default: prdata <= 32'h00000000;
        endcase
      end
      if (psel && !penable && !pwrite && paddr > `PC_OFS_CMD) begin
        pslverr <= 1'b1;
      end
    end
  end
  // Dual mode lines never differ
  property p_dual_lines;
    @(posedge clk) disable iff (rst)
    (cfg == preset_counter_pkg::CfgDual) |=> ##1
      (outputLineA == outputLineB) || $past(cfg) !=
      preset_counter_pkg::CfgDual;
  endproperty
  a_dual_lines: assert property (p_dual_lines)
    else $error("dual lines differ");
  property p_batch_zero;
    @(posedge clk) disable iff (rst)
    (resetB && cfg == preset_counter_pkg::CfgBatch) |=> aux_q == '0;
  endproperty
  a_batch_zero: assert property (p_batch_zero)
    else $error("batch count not held zero");
  property p_batch_hold;
    @(posedge clk) disable iff (rst)
    (batchOut_q && !keyPulse && !resetB) |=> batchOut_q;
  endproperty
  a_batch_hold: assert property (p_batch_hold)
    else $error("batch output dropped");
  property p_batch_setzero;
    @(posedge clk) disable iff (rst)
    (batchSet_q == '0 && !batchOut_q && !restorePulse) |=> !batchOut_q;
  endproperty
  a_batch_setzero: assert property (p_batch_setzero)
    else $error("batch output with zero set");
  property p_overflow_stop;
    @(posedge clk) disable iff (rst)
    (overflow_q && !keyPulse && !resetA) |=> $stable(pvA_q);
  endproperty
  a_overflow_stop: assert property (p_overflow_stop)
    else $error("counting after overflow");
  property p_reset_a;
    @(posedge clk) disable iff (rst)
    (resetA && cfg != preset_counter_pkg::CfgDual) |=> pv_q == '0;
  endproperty
  a_reset_a: assert property (p_reset_a)
    else $error("present value not cleared");
  property p_dual_a;
    @(posedge clk) disable iff (rst)
    (resetA && !resetB && !keyPulse &&
     cfg == preset_counter_pkg::CfgDual) |=> $stable(pvB_q) || $past(riseB);
  endproperty
  a_dual_a: assert property (p_dual_a)
    else $error("reset A disturbed input B");
  property p_batch_wrap;
    @(posedge clk) disable iff (rst)
    (complete && cfg == preset_counter_pkg::CfgBatch && !resetB &&
     !keyPulse && aux_q == fullScale) |=> aux_q == '0;
  endproperty
  a_batch_wrap: assert property (p_batch_wrap)
    else $error("batch count did not wrap");
endmodule : preset_counter

/* File: preset_counter_consts.svh */
// Constants for the batch and dual preset counter.
// Assumes inclusion by bare name from the design files.
`ifndef PRESET_COUNTER_CONSTS_SVH
`define PRESET_COUNTER_CONSTS_SVH
`define PC_MAX6 24'd999999
`define PC_MAX4 24'd9999
`define PC_NEGMIN6 25'd99999
`define PC_NEGMIN4 25'd999
// APB register byte offsets
`define PC_OFS_CTRL 12'h000
`define PC_OFS_PRESET 12'h004
`define PC_OFS_BATCHSET 12'h008
`define PC_OFS_DUALSET 12'h00c
`define PC_OFS_PV 12'h010
`define PC_OFS_AUX 12'h014
`define PC_OFS_PVA 12'h018
`define PC_OFS_PVB 12'h01c
`define PC_OFS_DUAL 12'h020
`define PC_OFS_STATUS 12'h024
`define PC_OFS_CMD 12'h028
// Control field positions
`define PC_CTRL_CFG_LSB 0
`define PC_CTRL_SUB_BIT 3
`define PC_CTRL_FOUR_BIT 4
// Command bits (write one to act)
`define PC_CMD_RESETKEY_BIT 0
`define PC_CMD_POWERRESTORE_BIT 1
`endif

/* File: preset_counter_pkg.sv */
// Types shared by the preset counter design.
// Assumes nothing beyond a SystemVerilog compiler.
package preset_counter_pkg;
  typedef enum logic [2:0] {
    CfgSingle,
    CfgTwoStage,
    CfgTotal,
    CfgBatch,
    CfgDual
  } config_t;
endpackage : preset_counter_pkg

/* File: pulse_edge.sv */
// Rising-edge detector for one synchronous count input.
// Assumes the input is already synchronous to clk.
`timescale 1ns/1ns
module pulse_edge (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Level in, pulse out
  input wire logic level,
  output logic rise
);
  logic prev_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= level;
    end
  end

  assign rise = level & ~prev_q;
endmodule : pulse_edge

/* File: tb_batch_and_dual_preset_counter.sv */
// Self-checking bench for the batch and dual preset counter.
// Assumes the design files and count_source are compiled first.
`timescale 1ns/1ns
`include "preset_counter_consts.svh"
module tb_batch_and_dual_preset_counter;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, errVal;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdVal;
  logic outputLineA, outputLineB, countInputA, countInputB, resetA, resetB;
  int n_mismatch = 0;
  int n_tests = 0;
  int cycles = 0;

  preset_counter dut_u (.clk(clk), .rst(rst), .countInputA(countInputA),
    .countInputB(countInputB), .resetA(resetA), .resetB(resetB),
    .outputLineA(outputLineA), .outputLineB(outputLineB), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  count_source src_u (.clk(clk), .countInputA(countInputA),
    .countInputB(countInputB), .resetA(resetA), .resetB(resetB));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Longest run is near 42300 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      n_mismatch++;
      $display("[ERR] %0t timeout", $time);
      conclude();
    end
  end

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude

  task automatic ck(input logic [31:0] got, exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask : ck

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt

  // Request held until pready is sampled high; an idle edge follows
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int w;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    w = 0;
    do begin
      @(posedge clk);
      w++;
    end while (pready !== 1'b1);
    ck(32'(w), 32'h1, "zero wait states");
    rdVal = prdata;
    errVal = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic rdChk(input logic [11:0] a, input logic [31:0] exp,
                       input string what);
    apb(1'b0, a, 32'h0);
    ck(rdVal, exp, what);
  endtask : rdChk

  task automatic ckLines(input logic [1:0] exp, input string what);
    // Batch output needs count, output and line stages to settle
    wt(2);
    ck({30'h0, outputLineA, outputLineB}, {30'h0, exp}, what);
  endtask : ckLines

  function automatic logic [31:0] ctl(input preset_counter_pkg::config_t c,
                                      input logic sub, input logic four);
    return {27'h0, four, sub, c};
  endfunction : ctl

  task automatic powerCycle;
    rst <= 1'b1;
    wt(3);
    rst <= 1'b0;
    wt(1);
  endtask : powerCycle

  task automatic testBatch;
    powerCycle();
    apb(1'b1, `PC_OFS_CTRL, ctl(preset_counter_pkg::CfgBatch, 1'b0, 1'b0));
    apb(1'b1, `PC_OFS_PRESET, 32'h2);
    apb(1'b1, `PC_OFS_BATCHSET, 32'h2);
    src_u.pulse(1'b0, 2);
    ckLines(2'b01, "one batch");
    src_u.pulse(1'b0, 2);
    ckLines(2'b11, "batch reached");
    rdChk(`PC_OFS_AUX, 32'h2, "batch count");
    apb(1'b1, `PC_OFS_BATCHSET, 32'h5);
    ckLines(2'b11, "set raised");
    src_u.hold(1'b0, 1'b1);
    src_u.pulse(1'b0, 4);
    rdChk(`PC_OFS_AUX, 32'h0, "held at zero");
    ckLines(2'b01, "reset b batch out");
    src_u.hold(1'b0, 1'b0);
    src_u.pulse(1'b0, 4);
    ckLines(2'b01, "below set");
    apb(1'b1, `PC_OFS_BATCHSET, 32'h1);
    wt(1);
    ckLines(2'b11, "set lowered");
    src_u.pulse(1'b0, 1);
    src_u.hold(1'b1, 1'b0);
    src_u.hold(1'b0, 1'b0);
    rdChk(`PC_OFS_PV, 32'h0, "reset a pv");
    ck({31'h0, outputLineB}, 32'h0, "reset a output");
    powerCycle();
    apb(1'b1, `PC_OFS_CTRL, ctl(preset_counter_pkg::CfgBatch, 1'b0, 1'b0));
    apb(1'b1, `PC_OFS_PRESET, 32'h2);
    apb(1'b1, `PC_OFS_CMD, 32'h2);
    ckLines(2'b10, "batch restored");
    apb(1'b1, `PC_OFS_CMD, 32'h1);
    wt(1);
    rdChk(`PC_OFS_AUX, 32'h0, "key batch");
    ckLines(2'b00, "key outputs");
    apb(1'b1, `PC_OFS_BATCHSET, 32'h0);
    src_u.pulse(1'b0, 4);
    rdChk(`PC_OFS_AUX, 32'h2, "set zero counts");
    ckLines(2'b01, "set zero no output");
    apb(1'b0, 12'h02c, 32'h0);
    ck({31'h0, errVal}, 32'h1, "unmapped error");
    ck(rdVal, 32'h0, "unmapped data");
    $display("batch test done");
  endtask : testBatch

  task automatic testWrap;
    powerCycle();
    apb(1'b1, `PC_OFS_CTRL, ctl(preset_counter_pkg::CfgBatch, 1'b0, 1'b1));
    apb(1'b1, `PC_OFS_PRESET, 32'h1);
    src_u.pulse(1'b0, 9998);
    rdChk(`PC_OFS_AUX, 32'h270e, "below wrap");
    src_u.pulse(1'b0, 1);
    rdChk(`PC_OFS_AUX, 32'h270f, "full scale");
    src_u.pulse(1'b0, 1);
    rdChk(`PC_OFS_AUX, 32'h0, "wrapped");
    $display("wrap test done");
  endtask : testWrap

  task automatic testTotal;
    powerCycle();
    apb(1'b1, `PC_OFS_CTRL, ctl(preset_counter_pkg::CfgTotal, 1'b0, 1'b0));
    apb(1'b1, `PC_OFS_PRESET, 32'h3);
    src_u.pulse(1'b0, 2);
    rdChk(`PC_OFS_AUX, 32'h2, "total count");
    src_u.hold(1'b0, 1'b1);
    src_u.hold(1'b0, 1'b0);
    rdChk(`PC_OFS_AUX, 32'h0, "total cleared");
    rdChk(`PC_OFS_PV, 32'h2, "pv kept");
    apb(1'b1, `PC_OFS_CTRL,
        ctl(preset_counter_pkg::CfgTwoStage, 1'b0, 1'b0));
    src_u.hold(1'b0, 1'b1);
    src_u.hold(1'b0, 1'b0);
    rdChk(`PC_OFS_PV, 32'h2, "two stage no effect");
    $display("total test done");
  endtask : testTotal

  task automatic testDual;
    powerCycle();
    apb(1'b1, `PC_OFS_CTRL, ctl(preset_counter_pkg::CfgDual, 1'b0, 1'b0));
    apb(1'b1, `PC_OFS_DUALSET, 32'h5);
    src_u.pulse(1'b0, 2);
    src_u.pulse(1'b1, 2);
    ckLines(2'b00, "no match");
    src_u.pulse(1'b1, 1);
    ckLines(2'b11, "match both lines");
    rdChk(`PC_OFS_DUAL, 32'h5, "sum");
    rdChk(`PC_OFS_PVA, 32'h2, "input a value");
    src_u.hold(1'b1, 1'b0);
    src_u.pulse(1'b0, 2);
    src_u.pulse(1'b1, 1);
    rdChk(`PC_OFS_PVA, 32'h0, "a stopped");
    rdChk(`PC_OFS_DUAL, 32'h4, "a as zero");
    ckLines(2'b00, "both off");
    src_u.hold(1'b0, 1'b0);
    rdChk(`PC_OFS_PVB, 32'h4, "b kept");
    src_u.hold(1'b0, 1'b1);
    src_u.pulse(1'b1, 1);
    src_u.pulse(1'b0, 1);
    rdChk(`PC_OFS_DUAL, 32'h1, "b as zero");
    src_u.hold(1'b0, 1'b0);
    rdChk(`PC_OFS_PVA, 32'h1, "a kept");
    rdChk(`PC_OFS_PVB, 32'h0, "b cleared");
    apb(1'b1, `PC_OFS_CMD, 32'h1);
    rdChk(`PC_OFS_DUAL, 32'h0, "key dual");
    rdChk(`PC_OFS_PVA, 32'h0, "key a");
    $display("dual test done");
  endtask : testDual

  task automatic testSub;
    powerCycle();
    apb(1'b1, `PC_OFS_CTRL, ctl(preset_counter_pkg::CfgDual, 1'b1, 1'b1));
    src_u.pulse(1'b1, 1000);
    rdChk(`PC_OFS_DUAL, 32'hfffffc19, "low limit");
    src_u.pulse(1'b0, 3);
    rdChk(`PC_OFS_DUAL, 32'hfffffc1b, "difference");
    src_u.pulse(1'b0, 9997);
    apb(1'b0, `PC_OFS_STATUS, 32'h0);
    ck({31'h0, rdVal[2]}, 32'h1, "overflow flag");
    $display("subtract test done");
  endtask : testSub

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    wt(3);
    rst <= 1'b0;
    wt(1);
    ckLines(2'b00, "after reset");
    testBatch();
    testWrap();
    testTotal();
    testDual();
    testSub();
    conclude();
  end
endmodule : tb_batch_and_dual_preset_counter
